// *** verilog/ssr_pkg.sv ***
package ssr_pkg;

	// Serial word layout
	localparam int WORD_W  = 24;
	localparam int SEL_W   = 2;
	localparam int FIELD_HI = 23;
	localparam int FIELD_LO = 2;
	localparam int FIELD_W = 22;

	// Field widths held by the digital section
	localparam int INT_W  = 9;
	localparam int FRAC_W = 12;
	localparam int MOD_W  = 12;
	localparam int REF_W  = 4;
	localparam int PRE_W  = 2;
	localparam int OSEL_W = 3;

	// Latch select codes in the two lowest shifted bits
	localparam logic [SEL_W-1:0] SEL_INTFRAC = 2'h0;
	localparam logic [SEL_W-1:0] SEL_DIVMOD  = 2'h1;
	localparam logic [SEL_W-1:0] SEL_CONTROL = 2'h2;
	localparam logic [SEL_W-1:0] SEL_NOISE   = 2'h3;

	// Reset contents of the latches
	localparam logic [INT_W-1:0]   INT_RST  = 9'h01F;
	localparam logic [FRAC_W-1:0]  FRAC_RST = 12'h000;
	localparam logic [MOD_W-1:0]   MOD_RST  = 12'h002;
	localparam logic [FIELD_W-1:0] WORD_RST = 22'h00_0000;

	// Comparator antibacklash pulse, least time rounded up
	localparam int MCLK_MHZ = 125;
	localparam int ABL_NS   = 3;
	localparam int ABL_RAW  = (ABL_NS * MCLK_MHZ + 999) / 1000;
	localparam int ABL_CYC  = (ABL_RAW < 1) ? 1 : ABL_RAW;
	localparam int ABL_W    = 4;

	// Width of the per-period pump activity counter
	localparam int PW_W = 8;

	typedef struct packed {
		logic              fastLock;
		logic [INT_W-1:0]  intVal;
		logic [FRAC_W-1:0] fracVal;
	} ssr_intfrac_t;

	typedef struct packed {
		logic              loadCtl;
		logic [OSEL_W-1:0] outSel;
		logic [PRE_W-1:0]  presc;
		logic [REF_W-1:0]  refDiv;
		logic [MOD_W-1:0]  modField;
	} ssr_divmod_t;

	typedef enum logic [OSEL_W-1:0] {
		OBS_HIZ,
		OBS_LOCK,
		OBS_FBDIV,
		OBS_REFDIV,
		OBS_HIGH,
		OBS_LOW
	} ssr_obs_t;

endpackage

// *** verilog/ssr_sync.sv ***
`timescale 1ns/1ps

// Two-stage synchroniser; the first stage feeds only the second
module ssr_sync #(
	parameter int W = 1
)(
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] stable_ff;

	// Metastability settles across one full period
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			meta_ff   <= '0;
			stable_ff <= '0;
		end
		else
		begin
			meta_ff   <= asyncIn;
			stable_ff <= meta_ff;
		end
	end

	assign syncOut = stable_ff;

endmodule

// *** verilog/ssr_divider.sv ***
`timescale 1ns/1ps

// Programmable counter on input steps; divisor 0 behaves as 1
module ssr_divider #(
	parameter int W = 4
)(
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         stepIn,
	input  wire logic [W-1:0] divisor,
	output logic              tick,
	output logic              scaled
);

	logic [W-1:0] cnt_ff;
	logic         tick_ff;
	logic         scaled_ff;
	logic [W:0]   cntNext;
	logic         atEnd;

	// Divisor changes act at once, compared against the next count
	assign cntNext = {1'b0, cnt_ff} + (W+1)'(1);
	assign atEnd   = cntNext >= {1'b0, divisor};

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			cnt_ff    <= '0;
			tick_ff   <= 1'b0;
			scaled_ff <= 1'b0;
		end
		else
		begin
			tick_ff <= stepIn & atEnd;
			if (stepIn)
				cnt_ff <= atEnd ? '0 : cntNext[W-1:0];
			if (stepIn & atEnd)
				scaled_ff <= ~scaled_ff;
		end
	end

	assign tick   = tick_ff;
	assign scaled = scaled_ff;

endmodule

// *** verilog/ssr_serial_load.sv ***
`timescale 1ns/1ps
// Function
// - MSB first, one bit per serial clock rise
// - Strobe rise copies word into one latch
// - Two lowest shifted bits pick the latch
// - 00 int/frac, 01 div/mod, 10 control, 11 noise
// - Modulus held until next int/frac write
// - Holds 4/9/12/12-bit divide and modulus fields
// - Int/frac word: fast-lock, integer, fraction
// - Div/mod word: load, select, prescale, ref, modulus
// - Select bits steer the observation pin
// - Locked output high with narrow low pulses
// - Comparator weighs reference against feedback edges
// - Pin shows lock, scaled feedback or reference
module ssr_serial_load #(
	parameter int LOCK_WIN = 2,
	parameter int LOCK_CNT = 8
)(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        sclk,
	input  wire logic        sdata,
	input  wire logic        latchStrobe,
	input  wire logic        refIn,
	input  wire logic        fbIn,
	output logic             observationOutputPin,
	output logic             observationOutputPinOe,
	output logic             pumpUp,
	output logic             pumpDown,
	output logic             lockDetect,
	output logic             wideBand,
	output logic             fastLockEnable,
	output logic             loadControlBit,
	output logic [8:0]       integerDivideField,
	output logic [11:0]      fractionField,
	output logic [11:0]      interpolatorModulusField,
	output logic [3:0]       referenceDivideField,
	output logic [1:0]       prescalerSettingBits,
	output logic [2:0]       outputSelectBits,
	output logic [21:0]      controlWord,
	output logic [21:0]      noiseSpurWord
);

	localparam int WORD_W  = ssr_pkg::WORD_W;
	localparam int FIELD_W = ssr_pkg::FIELD_W;
	localparam int INT_W   = ssr_pkg::INT_W;
	localparam int FRAC_W  = ssr_pkg::FRAC_W;
	localparam int MOD_W   = ssr_pkg::MOD_W;
	localparam int PW_W    = ssr_pkg::PW_W;
	localparam int ABL_W   = ssr_pkg::ABL_W;
	localparam int SYNC_W  = WORD_W + 3;
	localparam int LCNT_W  = $clog2(LOCK_CNT + 1);
	localparam logic [PW_W-1:0]   WIN_LIM = PW_W'(LOCK_WIN);
	localparam logic [LCNT_W-1:0] CNT_LIM = LCNT_W'(LOCK_CNT);
	localparam logic [ABL_W-1:0]  ABL_LIM = ABL_W'(ssr_pkg::ABL_CYC - 1);

	// ---------------- Link domain (serial clock) ----------------
	logic              linkRst1_ff;
	logic              linkRst2_ff;
	logic [WORD_W-1:0] shift_ff;
	logic [WORD_W-1:0] nxt_shift;

	// Reset reaches the link side through two serial clock edges
	always_ff @(posedge sclk)
	begin
		linkRst1_ff <= rst_b;
		linkRst2_ff <= linkRst1_ff;
	end

	// New bit enters at the bottom so the first bit ends on top
	assign nxt_shift = {shift_ff[WORD_W-2:0], sdata};

	always_ff @(posedge sclk)
	begin
		if (!linkRst2_ff)
			shift_ff <= '0;
		else
			shift_ff <= nxt_shift;
	end

	// ---------------- Crossing into mclk ----------------
	logic [SYNC_W-1:0] syncIn;
	logic [SYNC_W-1:0] syncOut;
	logic              leSync;
	logic              refSync;
	logic              fbSync;
	logic [WORD_W-1:0] wordSync;

	// Word is quasi-static: the serial clock is still while the
	// strobe is high, so the strobe acts as the request
	assign syncIn = {latchStrobe, refIn, fbIn, shift_ff};

	ssr_sync #(
		.W(SYNC_W)
	) uSync (
		.clk     (mclk),
		.rst_b   (rst_b),
		.asyncIn (syncIn),
		.syncOut (syncOut)
	);

	assign leSync   = syncOut[SYNC_W-1];
	assign refSync  = syncOut[SYNC_W-2];
	assign fbSync   = syncOut[SYNC_W-3];
	assign wordSync = syncOut[WORD_W-1:0];

	logic leDly_ff;
	logic refDly_ff;
	logic fbDly_ff;
	logic leRise;
	logic refRise;
	logic fbRise;

	// Edge detectors on synchronised levels only
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			leDly_ff  <= 1'b0;
			refDly_ff <= 1'b0;
			fbDly_ff  <= 1'b0;
		end
		else
		begin
			leDly_ff  <= leSync;
			refDly_ff <= refSync;
			fbDly_ff  <= fbSync;
		end
	end

	assign leRise  = leSync & ~leDly_ff;
	assign refRise = refSync & ~refDly_ff;
	assign fbRise  = fbSync & ~fbDly_ff;

	// ---------------- Latch decode ----------------
	logic [ssr_pkg::SEL_W-1:0] selCode;
	logic                      wrIntFrac;
	logic                      wrDivMod;
	logic                      wrControl;
	logic                      wrNoise;
	logic [FIELD_W-1:0]        fieldBits;
	ssr_pkg::ssr_intfrac_t     ifWord;
	ssr_pkg::ssr_divmod_t      dmWord;

	// Exactly one write strobe per strobe rise
	assign selCode   = wordSync[ssr_pkg::SEL_W-1:0];
	assign wrIntFrac = leRise & (selCode == ssr_pkg::SEL_INTFRAC);
	assign wrDivMod  = leRise & (selCode == ssr_pkg::SEL_DIVMOD);
	assign wrControl = leRise & (selCode == ssr_pkg::SEL_CONTROL);
	assign wrNoise   = leRise & (selCode == ssr_pkg::SEL_NOISE);

	// Field views of the word above the select code
	assign fieldBits = wordSync[ssr_pkg::FIELD_HI:ssr_pkg::FIELD_LO];
	assign ifWord    = ssr_pkg::ssr_intfrac_t'(fieldBits);
	assign dmWord    = ssr_pkg::ssr_divmod_t'(fieldBits);

	// ---------------- Latches ----------------
	ssr_pkg::ssr_intfrac_t intFrac_ff;
	ssr_pkg::ssr_divmod_t  divMod_ff;
	logic [FIELD_W-1:0]    control_ff;
	logic [FIELD_W-1:0]    noise_ff;
	logic [MOD_W-1:0]      modHold_ff;
	logic [MOD_W-1:0]      modActive_ff;
	logic [MOD_W-1:0]      timerHold_ff;

	// Four latches written from the shift register
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			intFrac_ff <= '{1'b0, ssr_pkg::INT_RST, ssr_pkg::FRAC_RST};
			divMod_ff  <= ssr_pkg::ssr_divmod_t'(ssr_pkg::WORD_RST);
			control_ff <= ssr_pkg::WORD_RST;
			noise_ff   <= ssr_pkg::WORD_RST;
		end
		else
		begin
			if (wrIntFrac)
				intFrac_ff <= ifWord;
			if (wrDivMod)
				divMod_ff <= dmWord;
			if (wrControl)
				control_ff <= fieldBits;
			if (wrNoise)
				noise_ff <= fieldBits;
		end
	end

	// Double-buffered modulus: a glitch-free change needs the
	// integer and fraction to move with it, hence the wait
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			modHold_ff   <= ssr_pkg::MOD_RST;
			modActive_ff <= ssr_pkg::MOD_RST;
			timerHold_ff <= '0;
		end
		else
		begin
			if (wrDivMod & ~dmWord.loadCtl)
				modHold_ff <= dmWord.modField;
			if (wrDivMod & dmWord.loadCtl)
				timerHold_ff <= dmWord.modField;
			if (wrIntFrac)
				modActive_ff <= modHold_ff;
		end
	end

	// ---------------- Dividers ----------------
	logic             refTick;
	logic             refScaled;
	logic             fbTick;
	logic             fbScaled;
	logic [INT_W:0]   fbDivisor_ff;

	ssr_divider #(
		.W(ssr_pkg::REF_W)
	) uRefDiv (
		.clk     (mclk),
		.rst_b   (rst_b),
		.stepIn  (refRise),
		.divisor (divMod_ff.refDiv),
		.tick    (refTick),
		.scaled  (refScaled)
	);

	ssr_divider #(
		.W(INT_W + 1)
	) uFbDiv (
		.clk     (mclk),
		.rst_b   (rst_b),
		.stepIn  (fbRise),
		.divisor (fbDivisor_ff),
		.tick    (fbTick),
		.scaled  (fbScaled)
	);

	// ---------------- Fractional interpolator ----------------
	logic [FRAC_W-1:0] acc_ff;
	logic [FRAC_W:0]   accSum;
	logic [FRAC_W:0]   accLess;
	logic              accWrap;
	logic [FRAC_W-1:0] nxt_acc;
	logic [INT_W:0]    nxt_fbDivisor;

	// First-order accumulator; a fraction at or above the
	// modulus just wraps every period and is not trapped
	assign accSum  = {1'b0, acc_ff} + {1'b0, intFrac_ff.fracVal};
	assign accWrap = accSum >= {1'b0, modActive_ff};
	assign accLess = accSum - {1'b0, modActive_ff};
	assign nxt_acc = accWrap ? accLess[FRAC_W-1:0] : accSum[FRAC_W-1:0];
	assign nxt_fbDivisor = {1'b0, intFrac_ff.intVal}
		+ {{INT_W{1'b0}}, accWrap};

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			acc_ff       <= '0;
			fbDivisor_ff <= {1'b0, ssr_pkg::INT_RST};
		end
		else if (wrIntFrac)
		begin
			acc_ff       <= '0;
			fbDivisor_ff <= {1'b0, ifWord.intVal};
		end
		else if (fbTick)
		begin
			acc_ff       <= nxt_acc;
			fbDivisor_ff <= nxt_fbDivisor;
		end
	end

	// ---------------- Phase frequency comparator ----------------
	logic             up_ff;
	logic             down_ff;
	logic [ABL_W-1:0] ablCnt_ff;
	logic             bothOn;
	logic             ablDone;
	logic             nxt_up;
	logic             nxt_down;
	logic             pumpOn;

	// Both sides stay on for the antibacklash time to avoid a
	// dead zone; an edge in the clearing cycle still sets
	assign bothOn   = up_ff & down_ff;
	assign ablDone  = bothOn & (ablCnt_ff >= ABL_LIM);
	assign nxt_up   = (up_ff & ~ablDone) | refTick;
	assign nxt_down = (down_ff & ~ablDone) | fbTick;
	assign pumpOn   = up_ff ^ down_ff;

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			up_ff     <= 1'b0;
			down_ff   <= 1'b0;
			ablCnt_ff <= '0;
		end
		else
		begin
			up_ff     <= nxt_up;
			down_ff   <= nxt_down;
			ablCnt_ff <= (bothOn & ~ablDone) ? ablCnt_ff + 1'b1 : '0;
		end
	end

	// ---------------- Lock detect ----------------
	logic [PW_W-1:0]   width_ff;
	logic [LCNT_W-1:0] goodCnt_ff;
	logic              lock_ff;
	logic              periodGood;
	logic              widthFull;

	// Lock after LOCK_CNT reference periods of small error
	assign periodGood = width_ff <= WIN_LIM;
	assign widthFull  = &width_ff;

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			width_ff   <= '0;
			goodCnt_ff <= '0;
			lock_ff    <= 1'b0;
		end
		else
		begin
			if (refTick)
				width_ff <= '0;
			else if (pumpOn & ~widthFull)
				width_ff <= width_ff + 1'b1;
			if (refTick & ~periodGood)
				goodCnt_ff <= '0;
			else if (refTick & (goodCnt_ff != CNT_LIM))
				goodCnt_ff <= goodCnt_ff + 1'b1;
			lock_ff <= goodCnt_ff == CNT_LIM;
		end
	end

	// ---------------- Fast-lock timer ----------------
	logic [MOD_W-1:0] flTimer_ff;
	logic             wideBand_ff;

	// Counts reference periods; a zero timer gives no wide band
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			flTimer_ff  <= '0;
			wideBand_ff <= 1'b0;
		end
		else
		begin
			if (wrIntFrac)
				flTimer_ff <= ifWord.fastLock ? timerHold_ff : '0;
			else if (refTick & (flTimer_ff != '0))
				flTimer_ff <= flTimer_ff - 1'b1;
			wideBand_ff <= flTimer_ff != '0;
		end
	end

	// ---------------- Observation pin ----------------
	ssr_pkg::ssr_obs_t obsSel;
	logic              selHiz;
	logic              selLock;
	logic              selFb;
	logic              selRef;
	logic              selHigh;
	logic              lockLevel;
	logic              nxt_obsOut;
	logic              nxt_obsOe;
	logic              obsOut_ff;
	logic              obsOe_ff;

	assign obsSel  = ssr_pkg::ssr_obs_t'(divMod_ff.outSel);
	assign selHiz  = obsSel == ssr_pkg::OBS_HIZ;
	assign selLock = obsSel == ssr_pkg::OBS_LOCK;
	assign selFb   = obsSel == ssr_pkg::OBS_FBDIV;
	assign selRef  = obsSel == ssr_pkg::OBS_REFDIV;
	assign selHigh = obsSel == ssr_pkg::OBS_HIGH;

	// Lock source is open drain: released while high, pulled
	// low whenever exactly one pump is active
	assign lockLevel  = lock_ff & ~pumpOn;
	assign nxt_obsOe  = selHiz ? 1'b0 : (selLock ? ~lockLevel : 1'b1);
	assign nxt_obsOut = selFb ? fbScaled : (selRef ? refScaled : selHigh);

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			obsOut_ff <= 1'b0;
			obsOe_ff  <= 1'b0;
		end
		else
		begin
			obsOut_ff <= nxt_obsOut;
			obsOe_ff  <= nxt_obsOe;
		end
	end

	// ---------------- Outputs ----------------
	assign observationOutputPin     = obsOut_ff;
	assign observationOutputPinOe   = obsOe_ff;
	assign pumpUp                   = up_ff;
	assign pumpDown                 = down_ff;
	assign lockDetect               = lock_ff;
	assign wideBand                 = wideBand_ff;
	assign fastLockEnable           = intFrac_ff.fastLock;
	assign loadControlBit           = divMod_ff.loadCtl;
	assign integerDivideField       = intFrac_ff.intVal;
	assign fractionField            = intFrac_ff.fracVal;
	assign interpolatorModulusField = modActive_ff;
	assign referenceDivideField     = divMod_ff.refDiv;
	assign prescalerSettingBits     = divMod_ff.presc;
	assign outputSelectBits         = divMod_ff.outSel;
	assign controlWord              = control_ff;
	assign noiseSpurWord            = noise_ff;

endmodule

// *** verif/ssr_serial_load_sva.sv ***
`timescale 1ns/1ps

// Port-level checks of the pin mux, comparator pulses and latch holding
module ssr_serial_load_sva (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        latchStrobe,
	input wire logic        observationOutputPin,
	input wire logic        observationOutputPinOe,
	input wire logic        pumpUp,
	input wire logic        pumpDown,
	input wire logic        lockDetect,
	input wire logic        wideBand,
	input wire logic        fastLockEnable,
	input wire logic [8:0]  integerDivideField,
	input wire logic [11:0] interpolatorModulusField,
	input wire logic [2:0]  outputSelectBits
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	// Pin follows the select bits one cycle later
	AST_SEL_OFF: assert property (
		outputSelectBits == 3'h0 |=> !observationOutputPinOe)
		else $error("Pin driven while deselected");
	AST_SEL_HIGH: assert property (
		outputSelectBits == 3'h4 |=> observationOutputPinOe && observationOutputPin)
		else $error("Pin not driven high");
	AST_SEL_LOW: assert property (
		outputSelectBits >= 3'h5 |=> observationOutputPinOe && !observationOutputPin)
		else $error("Pin not driven low");
	// Lock source is open drain: never drives a one, pulls low when unlocked
	AST_LOCK_OPEN_DRAIN: assert property (
		outputSelectBits == 3'h1 |=> !observationOutputPin)
		else $error("Lock source drove a high level");
	AST_UNLOCK_PULL: assert property (
		(outputSelectBits == 3'h1 && !lockDetect) [*2] |=> observationOutputPinOe)
		else $error("Unlocked pin not pulled low");
	// Both pumps together only for the one-cycle antibacklash pulse
	AST_ABL_PULSE: assert property (
		pumpUp && pumpDown |=> !(pumpUp && pumpDown))
		else $error("Pumps overlapped too long");
	// With no strobe in flight the latched fields cannot move
	AST_LATCH_HOLD: assert property (
		(!latchStrobe) [*6] |=> $stable(integerDivideField)
		&& $stable(interpolatorModulusField) && $stable(outputSelectBits))
		else $error("Latched field changed without strobe");
	AST_RESET_VALUES: assert property (
		$rose(rst_b) |-> integerDivideField == ssr_pkg::INT_RST
		&& interpolatorModulusField == ssr_pkg::MOD_RST)
		else $error("Wrong field values out of reset");
	AST_WIDE_OFF: assert property (
		(!fastLockEnable) [*2] |-> !wideBand)
		else $error("Wide band without fast lock");

	COV_LOCK: cover property ($rose(lockDetect));
	COV_WIDE: cover property ($rose(wideBand));
	COV_MOD: cover property ($changed(interpolatorModulusField));
endmodule

bind ssr_serial_load ssr_serial_load_sva chk (
	.mclk                     (mclk),
	.rst_b                    (rst_b),
	.latchStrobe              (latchStrobe),
	.observationOutputPin     (observationOutputPin),
	.observationOutputPinOe   (observationOutputPinOe),
	.pumpUp                   (pumpUp),
	.pumpDown                 (pumpDown),
	.lockDetect               (lockDetect),
	.wideBand                 (wideBand),
	.fastLockEnable           (fastLockEnable),
	.integerDivideField       (integerDivideField),
	.interpolatorModulusField (interpolatorModulusField),
	.outputSelectBits         (outputSelectBits)
);

// *** verif/ssr_host_model.sv ***
`timescale 1ns/1ps

// Host end of the three-wire link; serial clock runs inside frames and in bare reset pulses
module ssr_host_model (
	input  wire logic mclk,
	output logic      sclk,
	output logic      sdata,
	output logic      latchStrobe
);
	initial
	begin
		sclk = 1'b0;
		sdata = 1'b0;
		latchStrobe = 1'b0;
	end

	// Shift one word at a 6 ns bit period, odd phase against mclk
	task automatic shiftWord(input logic [23:0] w);
		#1.7;
		for (int i = 23; i >= 0; i--)
		begin
			sdata = w[i];
			#3;
			sclk = 1'b1;
			#3;
			sclk = 1'b0;
		end
		// Released data line shows the inverse, never a stale bit
		sdata = ~w[0];
	endtask

	// Bare clock pulses with the strobe low; lets the link side see
	// the reset, and any stray bits are pushed out by the next word
	task automatic pulseClock(input int n);
		for (int i = 0; i < n; i++)
		begin
			#3;
			sclk = 1'b1;
			#3;
			sclk = 1'b0;
		end
	endtask

	// Strobe rises only after the last bit; link stays still around it
	task automatic sendWord(input logic [23:0] w);
		shiftWord(w);
		repeat (2) @(negedge mclk);
		latchStrobe = 1'b1;
		repeat (4) @(negedge mclk);
		latchStrobe = 1'b0;
		repeat (4) @(negedge mclk);
	endtask
endmodule

// *** verif/ssr_serial_load_tb_top.sv ***
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
	begin \
		samplesChecked++; \
		if ((got) !== (exp)) \
		begin \
			numErrors++; \
			$display("[FAIL] %0s expected %h seen %h", nm, exp, got); \
		end \
	end

module ssr_serial_load_tb_top;
	logic        mclk, rst_b, sclk, sdata, latchStrobe, refIn, fbIn;
	logic        observationOutputPin, observationOutputPinOe, pinWire;
	logic        pumpUp, pumpDown, lockDetect, wideBand;
	logic        fastLockEnable, loadControlBit;
	logic [8:0]  integerDivideField;
	logic [11:0] fractionField, interpolatorModulusField;
	logic [3:0]  referenceDivideField;
	logic [1:0]  prescalerSettingBits;
	logic [2:0]  outputSelectBits;
	logic [21:0] controlWord, noiseSpurWord;
	int          numErrors;
	int          samplesChecked;

	ssr_serial_load #(.LOCK_WIN(2), .LOCK_CNT(2)) dut (.*);

	ssr_host_model host (
		.mclk        (mclk),
		.sclk        (sclk),
		.sdata       (sdata),
		.latchStrobe (latchStrobe)
	);

	// Pull-up on the shared pin when nobody drives it
	assign pinWire = observationOutputPinOe ? observationOutputPin : 1'b1;

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	function automatic logic [23:0] dm(input logic ld, input logic [2:0] os,
		input logic [3:0] rd, input logic [11:0] md);
		ssr_pkg::ssr_divmod_t f;
		f = '{ld, os, 2'h2, rd, md};
		return {f, ssr_pkg::SEL_DIVMOD};
	endfunction

	function automatic logic [23:0] nf(input logic fl, input logic [8:0] iv,
		input logic [11:0] fv);
		ssr_pkg::ssr_intfrac_t f;
		f = '{fl, iv, fv};
		return {f, ssr_pkg::SEL_INTFRAC};
	endfunction

	task automatic tReset();
		`CHK("intRst", ssr_pkg::INT_RST, integerDivideField);
		`CHK("fracRst", ssr_pkg::FRAC_RST, fractionField);
		`CHK("modRst", ssr_pkg::MOD_RST, interpolatorModulusField);
		`CHK("ctlRst", ssr_pkg::WORD_RST, controlWord);
		`CHK("oeRst", 1'b0, observationOutputPinOe);
	endtask

	// New modulus waits in the holding stage until int/frac is written
	task automatic tModulus();
		host.sendWord(dm(1'b0, 3'h4, 4'hB, 12'hFFF));
		`CHK("refDiv", 4'hB, referenceDivideField);
		`CHK("presc", 2'h2, prescalerSettingBits);
		`CHK("outSel", 3'h4, outputSelectBits);
		`CHK("loadCtl", 1'b0, loadControlBit);
		`CHK("modHeld", 12'h002, interpolatorModulusField);
		`CHK("pinHigh", 1'b1, pinWire);
		host.sendWord(nf(1'b0, 9'h1FF, 12'hA5C));
		`CHK("intMax", 9'h1FF, integerDivideField);
		`CHK("fracVal", 12'hA5C, fractionField);
		`CHK("modApplied", 12'hFFF, interpolatorModulusField);
		`CHK("outSelKept", 3'h4, outputSelectBits);
	endtask

	task automatic tOtherLatches();
		host.sendWord({22'h2A_5C3E, ssr_pkg::SEL_CONTROL});
		`CHK("ctlWord", 22'h2A_5C3E, controlWord);
		host.sendWord({22'h15_A3C1, ssr_pkg::SEL_NOISE});
		`CHK("noiseWord", 22'h15_A3C1, noiseSpurWord);
		`CHK("ctlKept", 22'h2A_5C3E, controlWord);
		`CHK("intKept", 9'h1FF, integerDivideField);
	endtask

	// Every select code; unlocked lock source pulls the pin low
	task automatic tSelect();
		for (int s = 0; s < 8; s++)
		begin
			host.sendWord(dm(1'b0, s[2:0], 4'hB, 12'hFFF));
			@(negedge mclk);
			`CHK("selOe", s != 0, observationOutputPinOe);
			if (s == 1 || s >= 4)
				`CHK("selLevel", s == 4, pinWire);
		end
	endtask

	// One feedback edge, optionally with a reference edge alongside
	task automatic fbPulse(input logic withRef);
		fbIn = 1'b1;
		refIn = withRef;
		repeat (4) @(negedge mclk);
		fbIn = 1'b0;
		refIn = 1'b0;
		repeat (4) @(negedge mclk);
	endtask

	// Timer load keeps the held modulus; aligned edges bring lock
	task automatic tLock();
		int n;
		host.sendWord(dm(1'b1, 3'h1, 4'h1, 12'h003));
		host.sendWord(nf(1'b1, 9'h01F, 12'h000));
		`CHK("fastLock", 1'b1, fastLockEnable);
		`CHK("modKept", 12'hFFF, interpolatorModulusField);
		`CHK("wideOn", 1'b1, wideBand);
		n = 0;
		while (pumpDown !== 1'b1 && n < 40)
		begin
			fbPulse(1'b0);
			n++;
		end
		`CHK("fbTick", 1'b1, pumpDown);
		repeat (5)
		begin
			repeat (30) fbPulse(1'b0);
			fbPulse(1'b1);
		end
		repeat (8) @(negedge mclk);
		`CHK("locked", 1'b1, lockDetect);
		`CHK("wideOff", 1'b0, wideBand);
		`CHK("pinLocked", 1'b1, pinWire);
		`CHK("upIdle", 1'b0, pumpUp);
		// Five reference edges so far: scaled reference now high
		host.sendWord(dm(1'b1, 3'h3, 4'h1, 12'h003));
		`CHK("loadCtlSet", 1'b1, loadControlBit);
		`CHK("refScaledHi", 1'b1, pinWire);
		fbPulse(1'b1);
		`CHK("refScaledLo", 1'b0, pinWire);
	endtask

	task automatic wrapUp();
		$display("Checks %0d, errors %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		rst_b = 1'b0;
		refIn = 1'b0;
		fbIn = 1'b0;
		numErrors = 0;
		samplesChecked = 0;
		// Link side only resets on serial clock edges, so pulse it here
		fork
			host.pulseClock(4);
			repeat (5) @(negedge mclk);
		join
		rst_b = 1'b1;
		@(negedge mclk);
		tReset();
		// Dummy frame lets the link side leave reset before real words
		host.shiftWord(24'h00_0000);
		tModulus();
		tOtherLatches();
		tSelect();
		tLock();
		wrapUp();
	end

	// Sequence needs about 16 us; a hang is cut off well beyond that
	initial
	begin
		#100000;
		numErrors++;
		$display("[FAIL] watchdog expected done seen hang");
		wrapUp();
	end
endmodule
